/* File: logic/cell_protection_defs.svh */
// named constants of the cell protection monitor: register offsets, defaults, fixed-point scales
// assumes inclusion by bare name from the design file
`ifndef CELL_PROTECTION_DEFS_SVH
`define CELL_PROTECTION_DEFS_SVH
// register offsets on the plain port
`define ADDR_VOLT_TRIP_LEVEL 4'h0
`define ADDR_VOLT_TRIP_DELAY 4'h1
`define ADDR_VOLT_RECOVER_LEVEL 4'h2
`define ADDR_UV_TRIP_LEVEL 4'h3
`define ADDR_UV_TRIP_DELAY 4'h4
`define ADDR_UV_RECOVER_LEVEL 4'h5
`define ADDR_BODY_DIODE_LEVEL 4'h6
`define ADDR_CHARGE_HOT 4'h7
`define ADDR_DISCHARGE_HOT 4'h8
`define ADDR_HW_CFG 4'h9
`define ADDR_CHG_PERCENT 4'hA
`define ADDR_GAIN 4'hB
`define ADDR_OFFSETS 4'hC
`define ADDR_STATUS 4'hD
`define ADDR_CURRENT 4'hE
`define ADDR_VOLTAGE 4'hF
// defaults: mV, mA, 0.1 degC, seconds
`define DEF_VOLT_TRIP_LEVEL 16'h1126
`define DEF_VOLT_TRIP_DELAY 8'h01
`define DEF_VOLT_RECOVER_LEVEL 16'h10C2
`define DEF_UV_TRIP_LEVEL 16'h0AF0
`define DEF_UV_TRIP_DELAY 8'h01
`define DEF_UV_RECOVER_LEVEL 16'h0B54
`define DEF_BODY_DIODE_LEVEL 16'h003C
`define DEF_CHARGE_HOT_LEVEL 16'h0226
`define DEF_CHARGE_HOT_TIME 8'h05
`define DEF_CHARGE_HOT_RECOVER 16'h01F4
`define DEF_DISCHARGE_HOT_LEVEL 16'h0258
`define DEF_DISCHARGE_HOT_TIME 8'h05
`define DEF_DISCHARGE_HOT_RECOVER 16'h0226
`define DEF_HW_CURRENT_TRIP_CFG 8'h0A
`define DEF_HW_VOLT_TRIP_CFG 8'h07
`define DEF_PROT_CHECKSUM 8'h11
`define DEF_CHG_PERCENT_LOW 8'h32
`define DEF_CHG_PERCENT_MID 8'h50
// gains in micro-ohm, offsets in uA and nA
`define DEF_COUNTER_CURRENT_GAIN 16'h1388
`define DEF_COUNTER_CHARGE_GAIN 16'h13D2
`define DEF_COUNTER_HW_OFFSET 16'h1ADA
`define DEF_BOARD_OFFSET 16'h0294
`define DEF_PACK_V_OFFSET 16'h0000
// band boundaries in 0.1 degC, percent scale
`define TEMP_T2 16'h0064
`define TEMP_T5 16'h0258
`define PERCENT_DIV 24'h00_0064
// sense voltage in nV, so nV / micro-ohm = mA, then offsets in uA
`define UA_PER_MA 32'h0000_03E8
`define NA_PER_UA 32'h0000_03E8
// status bit positions
`define ST_OV 0
`define ST_UV 1
`define ST_CHG_HOT 2
`define ST_DSG_HOT 3
`define ST_CKSUM 4
`define ST_CHG_ON 5
`define ST_DSG_ON 6
`endif

/* File: logic/cell_protection_pkg.sv */
// types shared by the cell protection monitor
// assumes the defs header sits beside it
`default_nettype none
package cell_protection_pkg;
  typedef struct packed {
    logic [15:0] trip;
    logic [15:0] recover;
    logic [7:0] delay;
  } threshold_t;
  typedef struct packed {
    logic [15:0] cell_mv;
    logic signed [15:0] temp_dc;
    logic signed [31:0] sense_nv;
    logic [15:0] diode_ma;
  } measure_t;
  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_QUALIFY,
    ST_FAULT
  } guard_state_t;
endpackage
`default_nettype wire

/* File: logic/cell_protection_monitor.sv */
// cell protection monitor: fault qualification, switch control, calibration math, host register port
// assumes measurements and a one-second tick pulse arrive synchronous to sys_clk
//
// Our own choices: the plain strobed port and the register addresses.
`default_nettype none
`include "cell_protection_defs.svh"

module cell_protection_monitor
  import cell_protection_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tick_1s,
  input wire measure_t meas,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic chg_switch_on,
  output logic dsg_switch_on,
  output logic [15:0] chg_current_percent,
  output logic [7:0] hw_current_trip_cfg,
  output logic [7:0] hw_volt_trip_cfg,
  output logic signed [31:0] current_ma,
  output logic signed [31:0] charge_delta_ma,
  output logic [15:0] voltage_mv
);

  logic rst_meta_reg, rst_sync_n_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_n_reg;

  // configuration registers
  threshold_t ov_cfg_reg, uv_cfg_reg, chot_cfg_reg, dhot_cfg_reg;
  logic [15:0] diode_level_reg;
  logic [7:0] oc_cfg_reg, ovhw_cfg_reg, cksum_reg;
  logic [7:0] pct_low_reg, pct_mid_reg, pct_high_reg;
  logic [15:0] cur_gain_reg, chg_gain_reg, hw_off_reg, board_off_reg;
  logic signed [15:0] pack_off_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_cfg_reg <= '{`DEF_VOLT_TRIP_LEVEL, `DEF_VOLT_RECOVER_LEVEL, `DEF_VOLT_TRIP_DELAY};
      uv_cfg_reg <= '{`DEF_UV_TRIP_LEVEL, `DEF_UV_RECOVER_LEVEL, `DEF_UV_TRIP_DELAY};
      chot_cfg_reg <= '{`DEF_CHARGE_HOT_LEVEL, `DEF_CHARGE_HOT_RECOVER, `DEF_CHARGE_HOT_TIME};
      dhot_cfg_reg <= '{`DEF_DISCHARGE_HOT_LEVEL, `DEF_DISCHARGE_HOT_RECOVER, `DEF_DISCHARGE_HOT_TIME};
      diode_level_reg <= `DEF_BODY_DIODE_LEVEL;
      oc_cfg_reg <= `DEF_HW_CURRENT_TRIP_CFG;
      ovhw_cfg_reg <= `DEF_HW_VOLT_TRIP_CFG;
      cksum_reg <= `DEF_PROT_CHECKSUM;
      pct_low_reg <= `DEF_CHG_PERCENT_LOW;
      pct_mid_reg <= `DEF_CHG_PERCENT_MID;
      pct_high_reg <= `DEF_CHG_PERCENT_MID;
      cur_gain_reg <= `DEF_COUNTER_CURRENT_GAIN;
      chg_gain_reg <= `DEF_COUNTER_CHARGE_GAIN;
      hw_off_reg <= `DEF_COUNTER_HW_OFFSET;
      board_off_reg <= `DEF_BOARD_OFFSET;
      pack_off_reg <= `DEF_PACK_V_OFFSET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ADDR_VOLT_TRIP_LEVEL: ov_cfg_reg.trip <= reg_wdata[15:0];
        `ADDR_VOLT_TRIP_DELAY: ov_cfg_reg.delay <= reg_wdata[7:0];
        `ADDR_VOLT_RECOVER_LEVEL: ov_cfg_reg.recover <= reg_wdata[15:0];
        `ADDR_UV_TRIP_LEVEL: uv_cfg_reg.trip <= reg_wdata[15:0];
        `ADDR_UV_TRIP_DELAY: uv_cfg_reg.delay <= reg_wdata[7:0];
        `ADDR_UV_RECOVER_LEVEL: uv_cfg_reg.recover <= reg_wdata[15:0];
        `ADDR_BODY_DIODE_LEVEL: diode_level_reg <= reg_wdata[15:0];
        `ADDR_CHARGE_HOT: if (reg_wdata != 32'h0000_0000)
          chot_cfg_reg <= threshold_t'{reg_wdata[15:0], {8'h00, reg_wdata[31:24]}, reg_wdata[23:16]};
        `ADDR_DISCHARGE_HOT: if (reg_wdata != 32'h0000_0000)
          dhot_cfg_reg <= threshold_t'{reg_wdata[15:0], {8'h00, reg_wdata[31:24]}, reg_wdata[23:16]};
        `ADDR_HW_CFG: begin
          oc_cfg_reg <= reg_wdata[7:0];
          ovhw_cfg_reg <= reg_wdata[15:8];
          cksum_reg <= reg_wdata[23:16];
        end
        `ADDR_CHG_PERCENT: begin
          pct_low_reg <= reg_wdata[7:0];
          pct_mid_reg <= reg_wdata[15:8];
          pct_high_reg <= reg_wdata[23:16];
        end
        `ADDR_GAIN: begin
          cur_gain_reg <= reg_wdata[15:0];
          chg_gain_reg <= reg_wdata[31:16];
        end
        `ADDR_OFFSETS: begin
          hw_off_reg <= reg_wdata[15:0];
          board_off_reg <= reg_wdata[31:16];
        end
        `ADDR_STATUS: pack_off_reg <= reg_wdata[31:16];
        default: ;
      endcase
    end
  end

  // voltage with pack offset applied by sign
  logic [15:0] volt_next;
  always_comb begin
    volt_next = meas.cell_mv + pack_off_reg;
  end

  // qualification timers and fault state, one per condition
  logic ov_fault_reg, uv_fault_reg, chot_fault_reg, dhot_fault_reg;
  logic [7:0] ov_cnt_reg, uv_cnt_reg, chot_cnt_reg, dhot_cnt_reg;
  logic ov_cond, uv_cond, chot_cond, dhot_cond;
  logic ov_clear, uv_clear, chot_clear, dhot_clear;
  always_comb begin
    ov_cond = ov_cfg_reg.delay != 8'h00 && volt_next > ov_cfg_reg.trip;
    uv_cond = uv_cfg_reg.delay != 8'h00 && volt_next < uv_cfg_reg.trip;
    chot_cond = meas.temp_dc >= $signed(chot_cfg_reg.trip);
    dhot_cond = meas.temp_dc >= $signed(dhot_cfg_reg.trip);
    ov_clear = ov_cfg_reg.delay == 8'h00 || volt_next <= ov_cfg_reg.recover;
    uv_clear = uv_cfg_reg.delay == 8'h00 || volt_next >= uv_cfg_reg.recover;
    chot_clear = meas.temp_dc <= $signed(chot_cfg_reg.recover);
    dhot_clear = meas.temp_dc <= $signed(dhot_cfg_reg.recover);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_cnt_reg <= 8'h00;
      ov_fault_reg <= 1'b0;
    end else if (ov_fault_reg) begin
      ov_cnt_reg <= 8'h00;
      if (ov_clear) ov_fault_reg <= 1'b0;
    end else if (!ov_cond) begin
      ov_cnt_reg <= 8'h00;
    end else if (tick_1s) begin
      if (ov_cnt_reg + 8'h01 >= ov_cfg_reg.delay) ov_fault_reg <= 1'b1;
      else ov_cnt_reg <= ov_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_cnt_reg <= 8'h00;
      uv_fault_reg <= 1'b0;
    end else if (uv_fault_reg) begin
      uv_cnt_reg <= 8'h00;
      if (uv_clear) uv_fault_reg <= 1'b0;
    end else if (!uv_cond) begin
      uv_cnt_reg <= 8'h00;
    end else if (tick_1s) begin
      if (uv_cnt_reg + 8'h01 >= uv_cfg_reg.delay) uv_fault_reg <= 1'b1;
      else uv_cnt_reg <= uv_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chot_cnt_reg <= 8'h00;
      chot_fault_reg <= 1'b0;
    end else if (chot_fault_reg) begin
      chot_cnt_reg <= 8'h00;
      if (chot_clear) chot_fault_reg <= 1'b0;
    end else if (!chot_cond) begin
      chot_cnt_reg <= 8'h00;
    end else if (tick_1s) begin
      if (chot_cnt_reg + 8'h01 >= chot_cfg_reg.delay) chot_fault_reg <= 1'b1;
      else chot_cnt_reg <= chot_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dhot_cnt_reg <= 8'h00;
      dhot_fault_reg <= 1'b0;
    end else if (dhot_fault_reg) begin
      dhot_cnt_reg <= 8'h00;
      if (dhot_clear) dhot_fault_reg <= 1'b0;
    end else if (!dhot_cond) begin
      dhot_cnt_reg <= 8'h00;
    end else if (tick_1s) begin
      if (dhot_cnt_reg + 8'h01 >= dhot_cfg_reg.delay) dhot_fault_reg <= 1'b1;
      else dhot_cnt_reg <= dhot_cnt_reg + 8'h01;
    end
  end

  // checksum over the hardware protection bytes
  logic cksum_bad;
  always_comb begin
    cksum_bad = cksum_reg != 8'(oc_cfg_reg + ovhw_cfg_reg);
  end

  // switch control: faults open, body-diode current recloses a switch opened by its voltage fault, not by a hot fault
  logic diode_on;
  logic chg_diode_reg, dsg_diode_reg;
  logic chg_next, dsg_next;
  always_comb begin
    diode_on = meas.diode_ma >= diode_level_reg;
    chg_next = !(ov_fault_reg || chot_fault_reg)
      || ((diode_on || chg_diode_reg) && !chot_fault_reg);
    dsg_next = !(uv_fault_reg || dhot_fault_reg)
      || ((diode_on || dsg_diode_reg) && !dhot_fault_reg);
    if (cksum_bad) begin
      chg_next = 1'b0;
      dsg_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_switch_on <= 1'b0;
      dsg_switch_on <= 1'b0;
    end else begin
      chg_switch_on <= chg_next;
      dsg_switch_on <= dsg_next;
    end
  end

  // a reclose holds until its voltage fault clears: a closed switch shows no diode current
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_diode_reg <= 1'b0;
      dsg_diode_reg <= 1'b0;
    end else begin
      chg_diode_reg <= ov_fault_reg && (chg_diode_reg || diode_on);
      dsg_diode_reg <= uv_fault_reg && (dsg_diode_reg || diode_on);
    end
  end

  // second-level hardware configuration passes straight to the analog comparators
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_current_trip_cfg <= `DEF_HW_CURRENT_TRIP_CFG;
      hw_volt_trip_cfg <= `DEF_HW_VOLT_TRIP_CFG;
    end else begin
      hw_current_trip_cfg <= oc_cfg_reg;
      hw_volt_trip_cfg <= ovhw_cfg_reg;
    end
  end

  // charge current percentage by temperature band
  logic [7:0] pct_sel;
  always_comb begin
    if (meas.temp_dc < $signed(`TEMP_T2)) pct_sel = pct_low_reg;
    else if (meas.temp_dc < $signed(`TEMP_T5)) pct_sel = pct_mid_reg;
    else pct_sel = pct_high_reg;
  end

  // coulomb counter conversions
  logic signed [31:0] cur_next, dq_next, offs_ua;
  always_comb begin
    offs_ua = $signed({16'h0000, hw_off_reg}) + $signed({16'h0000, board_off_reg}) / $signed(`NA_PER_UA);
    cur_next = (meas.sense_nv / $signed({16'h0000, cur_gain_reg}) * $signed(`UA_PER_MA) - offs_ua)
      / $signed(`UA_PER_MA);
    dq_next = (meas.sense_nv / $signed({16'h0000, chg_gain_reg}) * $signed(`UA_PER_MA) - offs_ua)
      / $signed(`UA_PER_MA);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_ma <= 32'h0000_0000;
      charge_delta_ma <= 32'h0000_0000;
      voltage_mv <= 16'h0000;
      chg_current_percent <= 16'h0000;
    end else begin
      current_ma <= cur_next;
      charge_delta_ma <= dq_next;
      voltage_mv <= volt_next;
      chg_current_percent <= {8'h00, pct_sel};
    end
  end

  // register read port
  logic [31:0] rdata_next;
  always_comb begin
    unique case (reg_addr)
      `ADDR_VOLT_TRIP_LEVEL: rdata_next = {16'h0000, ov_cfg_reg.trip};
      `ADDR_VOLT_TRIP_DELAY: rdata_next = {24'h00_0000, ov_cfg_reg.delay};
      `ADDR_VOLT_RECOVER_LEVEL: rdata_next = {16'h0000, ov_cfg_reg.recover};
      `ADDR_UV_TRIP_LEVEL: rdata_next = {16'h0000, uv_cfg_reg.trip};
      `ADDR_UV_TRIP_DELAY: rdata_next = {24'h00_0000, uv_cfg_reg.delay};
      `ADDR_UV_RECOVER_LEVEL: rdata_next = {16'h0000, uv_cfg_reg.recover};
      `ADDR_BODY_DIODE_LEVEL: rdata_next = {16'h0000, diode_level_reg};
      `ADDR_CHARGE_HOT: rdata_next = {chot_cfg_reg.recover[7:0], chot_cfg_reg.delay, chot_cfg_reg.trip};
      `ADDR_DISCHARGE_HOT: rdata_next = {dhot_cfg_reg.recover[7:0], dhot_cfg_reg.delay, dhot_cfg_reg.trip};
      `ADDR_HW_CFG: rdata_next = {8'h00, cksum_reg, ovhw_cfg_reg, oc_cfg_reg};
      `ADDR_CHG_PERCENT: rdata_next = {8'h00, pct_high_reg, pct_mid_reg, pct_low_reg};
      `ADDR_GAIN: rdata_next = {chg_gain_reg, cur_gain_reg};
      `ADDR_OFFSETS: rdata_next = {board_off_reg, hw_off_reg};
      `ADDR_STATUS: rdata_next = {pack_off_reg, 9'h000, dsg_switch_on, chg_switch_on, cksum_bad,
        dhot_fault_reg, chot_fault_reg, uv_fault_reg, ov_fault_reg};
      `ADDR_CURRENT: rdata_next = current_ma;
      `ADDR_VOLTAGE: rdata_next = {chg_current_percent, voltage_mv};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 32'h0000_0000;
    else if (reg_rd) reg_rdata <= rdata_next;
    else reg_rdata <= 32'h0000_0000;
  end

  // assertions
  property p_ov_trip;
    @(posedge sys_clk) disable iff (!rst_n)
      (!ov_fault_reg && ov_cond && tick_1s && ov_cnt_reg + 8'h01 >= ov_cfg_reg.delay) |=> ov_fault_reg;
  endproperty
  a_ov_trip: assert property (p_ov_trip) else $error("overvoltage did not trip");

  property p_ov_off;
    @(posedge sys_clk) disable iff (!rst_n)
      (ov_cfg_reg.delay == 8'h00 && !ov_fault_reg) |=> !ov_fault_reg;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("disabled overvoltage still armed");

  property p_uv_trip;
    @(posedge sys_clk) disable iff (!rst_n)
      (!uv_fault_reg && uv_cond && tick_1s && uv_cnt_reg + 8'h01 >= uv_cfg_reg.delay) |=> uv_fault_reg;
  endproperty
  a_uv_trip: assert property (p_uv_trip) else $error("undervoltage did not trip");

  property p_ov_recover;
    @(posedge sys_clk) disable iff (!rst_n) (ov_fault_reg && ov_clear) |=> !ov_fault_reg;
  endproperty
  a_ov_recover: assert property (p_ov_recover) else $error("overvoltage did not recover");

  property p_timer_restart;
    @(posedge sys_clk) disable iff (!rst_n) !chot_cond |=> chot_cnt_reg == 8'h00;
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("timer kept counting");

  property p_cksum_open;
    @(posedge sys_clk) disable iff (!rst_n) cksum_bad |=> (!chg_switch_on && !dsg_switch_on);
  endproperty
  a_cksum_open: assert property (p_cksum_open) else $error("switches closed on bad checksum");

  property p_chot_open;
    @(posedge sys_clk) disable iff (!rst_n) (chot_fault_reg && !cksum_bad) |=> !chg_switch_on;
  endproperty
  a_chot_open: assert property (p_chot_open) else $error("charge switch closed while hot");

  property p_dhot_open;
    @(posedge sys_clk) disable iff (!rst_n) dhot_fault_reg |=> !dsg_switch_on;
  endproperty
  a_dhot_open: assert property (p_dhot_open) else $error("discharge switch closed while hot");

  property p_diode;
    @(posedge sys_clk) disable iff (!rst_n)
      (ov_fault_reg && !chot_fault_reg && diode_on && !cksum_bad) |=> chg_switch_on;
  endproperty
  a_diode: assert property (p_diode) else $error("body diode reclose missed");

  property p_uv_recover;
    @(posedge sys_clk) disable iff (!rst_n) (uv_fault_reg && uv_clear) |=> !uv_fault_reg;
  endproperty
  a_uv_recover: assert property (p_uv_recover) else $error("undervoltage did not recover");

  property p_diode_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (uv_fault_reg && (diode_on || dsg_diode_reg) && !dhot_fault_reg && !cksum_bad) |=> dsg_switch_on;
  endproperty
  a_diode_hold: assert property (p_diode_hold) else $error("discharge reclose not held");

  property p_dhot_recover;
    @(posedge sys_clk) disable iff (!rst_n) (dhot_fault_reg && dhot_clear) |=> !dhot_fault_reg;
  endproperty
  a_dhot_recover: assert property (p_dhot_recover) else $error("discharge hot did not recover");

endmodule
`default_nettype wire

/* File: bench/fet_gate_model.sv */
// far-side model: charge and discharge power switches with their body diodes
// assumes the switch enables come straight from the monitor and the bench sets the load current
`default_nettype none
module fet_gate_model
  import cell_protection_pkg::*;
(
  input wire logic chg_switch_on,
  input wire logic dsg_switch_on,
  input wire logic [15:0] load_ma,
  output logic [15:0] diode_ma
);
  timeunit 1ns;
  timeprecision 100ps;
  // an open switch pushes the load through its body diode; a closed pair carries none
  assign diode_ma = (chg_switch_on && dsg_switch_on) ? 16'h0000 : load_ma;
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench of the cell protection monitor
// assumes the package and the monitor are compiled first, fet_gate_model alongside
`default_nettype none
module tb
  import cell_protection_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, reset_n, tick_1s, reg_wr, reg_rd, chg_switch_on, dsg_switch_on;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] cell_mv, diode_ma, load_ma, chg_current_percent, voltage_mv;
  logic signed [15:0] temp_dc;
  logic signed [31:0] sense_nv, current_ma, charge_delta_ma;
  logic [7:0] hw_current_trip_cfg, hw_volt_trip_cfg;
  measure_t meas;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 32'h4a7a_c07d;
  assign meas = {cell_mv, temp_dc, sense_nv, diode_ma};
  cell_protection_monitor i_dut(.sys_clk, .reset_n, .tick_1s, .meas, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .chg_switch_on, .dsg_switch_on, .chg_current_percent, .hw_current_trip_cfg, .hw_volt_trip_cfg,
    .current_ma, .charge_delta_ma, .voltage_mv);
  fet_gate_model i_fet(.chg_switch_on, .dsg_switch_on, .load_ma, .diode_ma);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(name, reg_rdata & mask, exp);
  endtask
  function automatic logic [31:0] probe(input int k);
    case (k)
      0: return {30'h0000_0000, chg_switch_on, dsg_switch_on};
      1: return {16'h0000, chg_current_percent};
      2: return current_ma;
      3: return charge_delta_ma;
      4: return {16'h0000, voltage_mv};
      default: return {16'h0000, hw_volt_trip_cfg, hw_current_trip_cfg};
    endcase
  endfunction
  function automatic logic [7:0] band(input int t, input logic [7:0] lo, input logic [7:0] mi, input logic [7:0] hi);
    return (t < 100) ? lo : ((t < 600) ? mi : hi);
  endfunction
  // bounded wait for an output to settle on the expected value, then compare
  task automatic wait_chk(input string name, input int k, input logic [31:0] exp);
    for (int i = 0; i < 12 && probe(k) !== exp; i++) @(posedge sys_clk);
    #1;
    chk(name, probe(k), exp);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      tick_1s <= 1'b1;
      @(posedge sys_clk);
      tick_1s <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task automatic setm(input logic [15:0] mv, input logic [15:0] t, input int n);
    @(posedge sys_clk);
    cell_mv <= mv;
    temp_dc <= t;
    ticks(n);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
  initial begin
    logic [31:0] dflt [13];
    int corner [4];
    logic [7:0] lo, mi, hi;
    int t, k, g;
    dflt = '{32'h0000_1126, 32'h0000_0001, 32'h0000_10C2, 32'h0000_0AF0, 32'h0000_0001, 32'h0000_0B54,
      32'h0000_003C, 32'hF405_0226, 32'h2605_0258, 32'h0011_070A, 32'h0050_5032, 32'h13D2_1388, 32'h0294_1ADA};
    corner = '{99, 100, 599, 600};
    reset_n = 1'b0;
    tick_1s = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    cell_mv = 16'h0E74;
    temp_dc = 16'h00FA;
    sense_nv = 32'h0000_0000;
    load_ma = 16'h0000;
    repeat (4) @(posedge sys_clk);
    chk("cfg_in_reset", probe(5), 32'h0000_070A);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int a = 0; a < 13; a++) rd("reset_value", a[3:0], 32'hFFFF_FFFF, dflt[a]);
    rd("status_reset", 4'hD, 32'hFFFF_FFFF, 32'h0000_0060);
    wait_chk("pct_default", 1, 32'h0000_0050);
    done("reset");
    setm(16'h1126, 16'h00FA, 2);
    rd("ov_at_level", 4'hD, 32'h0000_0001, 32'h0000_0000);
    setm(16'h1127, 16'h00FA, 1);
    rd("ov_trip", 4'hD, 32'h0000_0001, 32'h0000_0001);
    chk("ov_open", probe(0), 32'h0000_0001);
    setm(16'h10C3, 16'h00FA, 1);
    rd("ov_held", 4'hD, 32'h0000_0001, 32'h0000_0001);
    setm(16'h10C2, 16'h00FA, 1);
    rd("ov_clear", 4'hD, 32'h0000_0001, 32'h0000_0000);
    wait_chk("ov_closed", 0, 32'h0000_0003);
    wr(4'h1, 32'h0000_0003);
    setm(16'h1127, 16'h00FA, 2);
    setm(16'h0FA0, 16'h00FA, 1);
    setm(16'h1127, 16'h00FA, 2);
    rd("ov_restart", 4'hD, 32'h0000_0001, 32'h0000_0000);
    ticks(1);
    rd("ov_three", 4'hD, 32'h0000_0001, 32'h0000_0001);
    setm(16'h10C2, 16'h00FA, 1);
    wr(4'h1, 32'h0000_0000);
    setm(16'h1194, 16'h00FA, 3);
    rd("ov_off", 4'hD, 32'h0000_0001, 32'h0000_0000);
    wr(4'h1, 32'h0000_0001);
    done("overvoltage");
    setm(16'h0AF0, 16'h00FA, 2);
    rd("uv_at_level", 4'hD, 32'h0000_0002, 32'h0000_0000);
    setm(16'h0AEF, 16'h00FA, 1);
    rd("uv_trip", 4'hD, 32'h0000_0002, 32'h0000_0002);
    chk("uv_open", probe(0), 32'h0000_0002);
    setm(16'h0B22, 16'h00FA, 0);
    load_ma <= 16'h003B;
    repeat (8) @(posedge sys_clk);
    chk("diode_low", probe(0), 32'h0000_0002);
    load_ma <= 16'h003C;
    wait_chk("diode_close", 0, 32'h0000_0003);
    load_ma <= 16'h0000;
    repeat (4) @(posedge sys_clk);
    chk("diode_hold", probe(0), 32'h0000_0003);
    setm(16'h0B53, 16'h00FA, 1);
    rd("uv_held", 4'hD, 32'h0000_0002, 32'h0000_0002);
    setm(16'h0B54, 16'h00FA, 1);
    rd("uv_clear", 4'hD, 32'h0000_0002, 32'h0000_0000);
    wr(4'h4, 32'h0000_0000);
    setm(16'h07D0, 16'h00FA, 3);
    rd("uv_off", 4'hD, 32'h0000_0002, 32'h0000_0000);
    setm(16'h0E74, 16'h00FA, 0);
    wr(4'h4, 32'h0000_0001);
    done("undervoltage");
    setm(16'h0E74, 16'h0226, 4);
    rd("chot_early", 4'hD, 32'h0000_0004, 32'h0000_0000);
    ticks(1);
    rd("chot_trip", 4'hD, 32'h0000_0004, 32'h0000_0004);
    wait_chk("chot_open", 0, 32'h0000_0001);
    setm(16'h0E74, 16'h01F5, 1);
    rd("chot_held", 4'hD, 32'h0000_0004, 32'h0000_0004);
    setm(16'h0E74, 16'h01F4, 1);
    rd("chot_clear", 4'hD, 32'h0000_0004, 32'h0000_0000);
    wait_chk("chot_closed", 0, 32'h0000_0003);
    setm(16'h0E74, 16'h0258, 5);
    rd("dhot_trip", 4'hD, 32'h0000_0008, 32'h0000_0008);
    wait_chk("dhot_open", 0, 32'h0000_0000);
    setm(16'h0E74, 16'h0227, 1);
    rd("dhot_held", 4'hD, 32'h0000_0008, 32'h0000_0008);
    setm(16'h0E74, 16'h0226, 1);
    rd("dhot_clear", 4'hD, 32'h0000_0008, 32'h0000_0000);
    setm(16'h0E74, 16'h00FA, 1);
    wait_chk("hot_closed", 0, 32'h0000_0003);
    wr(4'h7, 32'h0000_0000);
    rd("chot_keep", 4'h7, 32'hFFFF_FFFF, 32'hF405_0226);
    done("temperature");
    wr(4'h9, 32'h0011_080A);
    wait_chk("sum_open", 0, 32'h0000_0000);
    rd("sum_flag", 4'hD, 32'h0000_0010, 32'h0000_0010);
    wr(4'h9, 32'h0013_080B);
    wait_chk("sum_closed", 0, 32'h0000_0003);
    wait_chk("hw_cfg", 5, 32'h0000_080B);
    rd("sum_unflag", 4'hD, 32'h0000_0010, 32'h0000_0000);
    wr(4'h9, 32'h0011_070A);
    done("checksum");
    for (int i = 0; i < 24; i++) begin
      lo = $random(seed);
      mi = $random(seed);
      hi = $random(seed);
      t = (i < 4) ? corner[i] : $random(seed) % 1000;
      wr(4'hA, {8'h00, hi, mi, lo});
      setm(cell_mv, t[15:0], 0);
      wait_chk("pct_band", 1, {24'h00_0000, band(t, lo, mi, hi)});
    end
    wr(4'hA, 32'h0050_5032);
    setm(16'h0E74, 16'h00FA, 0);
    done("percent");
    wr(4'hC, 32'h0000_0000);
    for (int i = 0; i < 10; i++) begin
      g = 1000 + ($random(seed) & 32'h0000_3FFF);
      k = $random(seed) % 2000;
      wr(4'hB, {g[15:0], g[15:0] + 16'h0007});
      @(posedge sys_clk);
      sense_nv <= (g + 7) * k;
      wait_chk("current", 2, k);
      @(posedge sys_clk);
      sense_nv <= g * k;
      wait_chk("charge", 3, k);
    end
    wr(4'hC, 32'h0000_0BB8);
    @(posedge sys_clk);
    sense_nv <= (g + 7) * k;
    wait_chk("hw_offset", 2, k - 3);
    // 2000 mA through 1000 micro-ohm, less 65 uA of board offset, truncates to 1999 mA
    wr(4'hB, 32'h03E8_03E8);
    wr(4'hC, 32'hFFFF_0000);
    @(posedge sys_clk);
    sense_nv <= 32'h001E_8480;
    wait_chk("board_offset", 2, 32'h0000_07CF);
    wait_chk("board_charge", 3, 32'h0000_07CF);
    rd("current_reg", 4'hE, 32'hFFFF_FFFF, 32'h0000_07CF);
    wr(4'hC, 32'h0294_1ADA);
    wr(4'hD, 32'hFFFB_0000);
    wait_chk("volt_minus", 4, {16'h0000, cell_mv - 16'h0005});
    wr(4'hD, 32'h0007_0000);
    wait_chk("volt_plus", 4, {16'h0000, cell_mv + 16'h0007});
    wr(4'hF, 32'h0000_0000);
    wait_chk("volt_ro", 4, {16'h0000, cell_mv + 16'h0007});
    rd("volt_reg", 4'hF, 32'hFFFF_FFFF, {16'h0050, cell_mv + 16'h0007});
    done("calibration");
    conclude();
  end
endmodule
`default_nettype wire
